// ---- core/sdc_decoder.sv ----
// Command decoder, bank tracker and masked write path of the DDR memory device.
`timescale 1ns/1ps
`default_nettype none
module sdc_decoder #(
   parameter int DQ_W   = sdc_pkg::DQ_W,
   parameter int BANK_W = sdc_pkg::BANK_W,
   parameter int ADDR_W = sdc_pkg::ADDR_W,
   parameter int DEPTH  = sdc_pkg::FIFO_DEPTH
) (
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic                cke,
   input  wire logic                cs_n,
   input  wire logic                ras_n,
   input  wire logic                cas_n,
   input  wire logic                we_n,
   input  wire logic [BANK_W-1:0]   bank,
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire logic [DQ_W-1:0]     wdata_rise,
   input  wire logic [DQ_W-1:0]     wdata_fall,
   input  wire logic                low_byte_mask_rise,
   input  wire logic                high_byte_mask_rise,
   input  wire logic                low_byte_mask_fall,
   input  wire logic                high_byte_mask_fall,
   input  wire logic                wr_out_ready,
   output var  logic [DQ_W-1:0]     wr_out_data,
   output var  logic [1:0]          wr_out_strb,
   output var  logic                wr_out_valid,
   output var  logic [3:0]          cmd_code,
   output var  logic                cmd_illegal,
   output var  logic [7:0]          bank_open,
   output var  logic [1:0]          power_state,
   output var  logic                burst_busy,
   output var  logic                burst_is_write,
   output var  logic [3:0]          burst_beat,
   output var  logic [9:0]          burst_col,
   output var  logic [2:0]          burst_bank,
   output var  logic                zq_long,
   output var  logic [1:0]          mode_bl,
   output var  logic                mrs_strobe,
   output var  logic [2:0]          mrs_sel,
   output var  logic [ADDR_W-1:0]   mrs_op,
   output var  logic                fifo_overrun
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   localparam int PW = 5 + BANK_W + ADDR_W + 2 * DQ_W + 4;
   logic [PW-1:0] s1_r;
   logic [PW-1:0] s2_r;
   logic          cke_prev_r;

   // Inputs come from pins: two flops before anything reads them.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_r <= '0;
         s2_r <= '0;
      end
      else
      begin
         s1_r <= {cke, cs_n, ras_n, cas_n, we_n, bank, addr, wdata_rise, wdata_fall,
                  low_byte_mask_rise, high_byte_mask_rise,
                  low_byte_mask_fall, high_byte_mask_fall};
         s2_r <= s1_r;
      end
   end

   logic              c_cke;
   logic              c_cs_n;
   logic              c_ras_n;
   logic              c_cas_n;
   logic              c_we_n;
   logic [BANK_W-1:0] c_bank;
   logic [ADDR_W-1:0] c_addr;
   logic [DQ_W-1:0]   c_wr;
   logic [DQ_W-1:0]   c_wf;
   logic [3:0]        c_dm;
   assign {c_cke, c_cs_n, c_ras_n, c_cas_n, c_we_n, c_bank, c_addr, c_wr, c_wf, c_dm} = s2_r;

   // The clock enable level one cycle before the command.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cke_prev_r <= 1'b0;
      end
      else
      begin
         cke_prev_r <= c_cke;
      end
   end

   // ************************************************************
   // Command decode
   // ************************************************************
   function automatic sdc_pkg::sdc_cmd_t decode(input logic kp, input logic kn,
      input logic cs, input logic ras, input logic cas, input logic we, input logic a10);
      sdc_pkg::sdc_cmd_t c;
      logic nop_des;
      c = sdc_pkg::SDC_CMD_NONE;
      nop_des = cs || (ras && cas && we);
      if (!kp && kn && nop_des)
         c = sdc_pkg::SDC_CMD_PDX;
      else if (kp && !kn && nop_des)
         c = sdc_pkg::SDC_CMD_PDE;
      else if (kp && !kn && !cs && !ras && !cas && we)
         c = sdc_pkg::SDC_CMD_SRE;
      else if (kp && kn)
      begin
         case ({cs, ras, cas, we})
            4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: c = sdc_pkg::SDC_CMD_DES;
            4'h7: c = sdc_pkg::SDC_CMD_NOP;
            4'h3: c = sdc_pkg::SDC_CMD_ACT;
            4'h2: c = a10 ? sdc_pkg::SDC_CMD_PREA : sdc_pkg::SDC_CMD_PRE;
            4'h4: c = sdc_pkg::SDC_CMD_WR;
            4'h5: c = sdc_pkg::SDC_CMD_RD;
            4'h0: c = sdc_pkg::SDC_CMD_MRS;
            4'h1: c = sdc_pkg::SDC_CMD_REF;
            4'h6: c = a10 ? sdc_pkg::SDC_CMD_ZQL : sdc_pkg::SDC_CMD_ZQS;
            default: c = sdc_pkg::SDC_CMD_NONE;
         endcase
      end
      return c;
   endfunction : decode

   sdc_pkg::sdc_cmd_t cmd;
   assign cmd = decode(cke_prev_r, c_cke, c_cs_n, c_ras_n, c_cas_n, c_we_n,
                       c_addr[sdc_pkg::AP_BIT]);

   logic [sdc_pkg::NBANKS-1:0] open_r;
   logic [sdc_pkg::NBANKS-1:0] close_mask;
   logic                      bank_on;
   logic                      all_idle;
   sdc_pkg::sdc_pw_t          pw_r;
   logic                      busy_r;
   logic                      wr_r;
   logic                      ap_r;
   logic [2:0]                bb_r;
   logic [3:0]                beat_r;
   logic [3:0]                len_r;
   logic [9:0]                col_r;
   logic [1:0]                bl_r;
   logic                      legal;
   logic                      start;

   assign bank_on  = open_r[c_bank];
   assign all_idle = (open_r == '0) && !busy_r;

   always_comb
   begin
      case (cmd)
         sdc_pkg::SDC_CMD_ACT:   legal = !bank_on;
         sdc_pkg::SDC_CMD_WR,
         sdc_pkg::SDC_CMD_RD:    legal = bank_on && !busy_r;
         sdc_pkg::SDC_CMD_MRS,
         sdc_pkg::SDC_CMD_REF,
         sdc_pkg::SDC_CMD_SRE,
         sdc_pkg::SDC_CMD_ZQL,
         sdc_pkg::SDC_CMD_ZQS:   legal = all_idle;
         sdc_pkg::SDC_CMD_PDE:   legal = all_idle;
         sdc_pkg::SDC_CMD_PDX:   legal = (pw_r != sdc_pkg::SDC_PW_RUN);
         default:                legal = 1'b1;
      endcase
   end

   assign start = legal && (cmd == sdc_pkg::SDC_CMD_WR || cmd == sdc_pkg::SDC_CMD_RD);

   // ************************************************************
   // Bank state
   // ************************************************************
   always_comb
   begin
      close_mask = '0;
      if (legal && cmd == sdc_pkg::SDC_CMD_PREA)
         close_mask = '1;
      else if (legal && cmd == sdc_pkg::SDC_CMD_PRE)
         close_mask[c_bank] = 1'b1;
      if (busy_r && ap_r && beat_r == len_r)
         close_mask[bb_r] = 1'b1;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         open_r <= '0;
      end
      else
      begin
         open_r <= open_r & ~close_mask;
         if (legal && cmd == sdc_pkg::SDC_CMD_ACT)
            open_r[c_bank] <= 1'b1;
      end
   end

   // ************************************************************
   // Power state
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pw_r <= sdc_pkg::SDC_PW_RUN;
      end
      else if (legal)
      begin
         case (cmd)
            sdc_pkg::SDC_CMD_PDE: pw_r <= sdc_pkg::SDC_PW_PD;
            sdc_pkg::SDC_CMD_SRE: pw_r <= sdc_pkg::SDC_PW_SR;
            sdc_pkg::SDC_CMD_PDX: pw_r <= sdc_pkg::SDC_PW_RUN;
            default:              pw_r <= pw_r;
         endcase
      end
   end

   // ************************************************************
   // Mode register
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bl_r <= sdc_pkg::BL_FIXED8;
      end
      else if (legal && cmd == sdc_pkg::SDC_CMD_MRS && c_bank == sdc_pkg::MR0_SEL)
      begin
         bl_r <= c_addr[1:0];
      end
   end

   // ************************************************************
   // Burst sequencer
   // ************************************************************
   // Burst length follows the mode; bit twelve matters only in on-the-fly mode.
   function automatic logic [3:0] burst_len(input logic [1:0] mode, input logic bc);
      logic [3:0] n;
      n = sdc_pkg::BEATS8;
      if (mode == sdc_pkg::BL_FIXED4)
         n = sdc_pkg::BEATS4;
      else if (mode == sdc_pkg::BL_OTF)
         n = bc ? sdc_pkg::BEATS8 : sdc_pkg::BEATS4;
      return n;
   endfunction : burst_len

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busy_r <= 1'b0;
         wr_r   <= 1'b0;
         ap_r   <= 1'b0;
         bb_r   <= '0;
         beat_r <= '0;
         len_r  <= '0;
         col_r  <= '0;
      end
      else if (start)
      begin
         busy_r <= 1'b1;
         wr_r   <= (cmd == sdc_pkg::SDC_CMD_WR);
         ap_r   <= c_addr[sdc_pkg::AP_BIT];
         bb_r   <= c_bank;
         beat_r <= 4'h2;
         len_r  <= burst_len(bl_r, c_addr[sdc_pkg::BC_BIT]);
         col_r  <= c_addr[sdc_pkg::COL_W-1:0];
      end
      else if (busy_r)
      begin
         // Two beats per clock: eight beats take four clocks.
         if (beat_r == len_r)
            busy_r <= 1'b0;
         else
            beat_r <= beat_r + 4'h2;
      end
   end

   // ************************************************************
   // Masked write path
   // ************************************************************
   // Both pin words of a write cycle enter the FIFO together as one entry, so while it has room
   // none is lost; the output side hands them out one at a time, rise first.
   localparam int EW = DQ_W + 2;
   logic [2*EW-1:0] f_in;
   logic            f_ready;
   logic            in_write;
   logic [2*EW-1:0] f_out;
   logic            f_out_valid;
   logic [EW-1:0]   f_word;
   logic            take;
   logic            half_r;
   logic            ovr_r;

   assign in_write = busy_r && wr_r;
   // Strobe bit set means the lane is written; each mask gates only its byte.
   assign f_in     = {~{c_dm[0], c_dm[1]}, c_wf,
                      ~{c_dm[2], c_dm[3]}, c_wr};
   assign f_word   = half_r ? f_out[2*EW-1:EW] : f_out[EW-1:0];
   assign take     = f_out_valid && (!wr_out_valid || wr_out_ready);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         half_r <= 1'b0;
         ovr_r  <= 1'b0;
      end
      else
      begin
         if (take)
            half_r <= !half_r;
         // The pins cannot be stalled, so a full FIFO drops data and flags it.
         if (in_write && !f_ready)
            ovr_r <= 1'b1;
      end
   end

   sdc_fifo #(
      .WIDTH (2 * EW),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_data   (f_in),
      .in_valid  (in_write),
      .in_ready  (f_ready),
      .out_data  (f_out),
      .out_valid (f_out_valid),
      .out_ready (take && half_r)
   );

   // ************************************************************
   // Registered outputs
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_out_data    <= '0;
         wr_out_strb    <= '0;
         wr_out_valid   <= 1'b0;
         cmd_code       <= 4'h0;
         cmd_illegal    <= 1'b0;
         bank_open      <= '0;
         power_state    <= 2'h0;
         burst_busy     <= 1'b0;
         burst_is_write <= 1'b0;
         burst_beat     <= '0;
         burst_col      <= '0;
         burst_bank     <= '0;
         zq_long        <= 1'b0;
         mode_bl        <= 2'h0;
         mrs_strobe     <= 1'b0;
         mrs_sel        <= '0;
         mrs_op         <= '0;
         fifo_overrun   <= 1'b0;
      end
      else
      begin
         if (take)
         begin
            wr_out_data  <= f_word[DQ_W-1:0];
            wr_out_strb  <= f_word[EW-1:DQ_W];
            wr_out_valid <= 1'b1;
         end
         else if (wr_out_ready)
         begin
            wr_out_valid <= 1'b0;
         end
         cmd_code       <= legal ? cmd : sdc_pkg::SDC_CMD_NONE;
         cmd_illegal    <= !legal;
         bank_open      <= open_r;
         power_state    <= pw_r;
         burst_busy     <= busy_r;
         burst_is_write <= wr_r;
         burst_beat     <= beat_r;
         burst_col      <= col_r;
         burst_bank     <= bb_r;
         if (legal && cmd == sdc_pkg::SDC_CMD_ZQL)
            zq_long <= 1'b1;
         else if (legal && cmd == sdc_pkg::SDC_CMD_ZQS)
            zq_long <= 1'b0;
         mode_bl        <= bl_r;
         mrs_strobe     <= legal && cmd == sdc_pkg::SDC_CMD_MRS;
         mrs_sel        <= c_bank;
         mrs_op         <= c_addr;
         fifo_overrun   <= ovr_r;
      end
   end
endmodule : sdc_decoder
`default_nettype wire

// ---- core/sdc_pkg.sv ----
// Package with the constants shared by the command decoder design.
package sdc_pkg;
   // ************************************************************
   // Geometry
   // ************************************************************
   localparam int BANK_W  = 3;
   localparam int ADDR_W  = 13;
   localparam int NBANKS  = 8;
   localparam int DQ_W    = 16;
   localparam int BYTE_W  = 8;
   localparam int BEAT_W  = 4;
   localparam int AP_BIT  = 10;
   localparam int BC_BIT  = 12;
   localparam int ROW_W   = 13;
   localparam int COL_W   = 10;
   localparam int FIFO_DEPTH = 32;

   // ************************************************************
   // Burst and mode settings
   // ************************************************************
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF    = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;
   localparam logic [3:0] BEATS8    = 4'h8;
   localparam logic [3:0] BEATS4    = 4'h4;
   localparam logic [2:0] MR0_SEL   = 3'h0;
   localparam logic [1:0] MR0_BL_LO = 2'h0;

   // ************************************************************
   // Decoded commands
   // ************************************************************
   typedef enum logic [3:0]
   {
      SDC_CMD_NONE  = 4'h0,
      SDC_CMD_ACT   = 4'h1,
      SDC_CMD_PRE   = 4'h2,
      SDC_CMD_PREA  = 4'h3,
      SDC_CMD_WR    = 4'h4,
      SDC_CMD_RD    = 4'h5,
      SDC_CMD_MRS   = 4'h6,
      SDC_CMD_NOP   = 4'h7,
      SDC_CMD_DES   = 4'h8,
      SDC_CMD_REF   = 4'h9,
      SDC_CMD_SRE   = 4'ha,
      SDC_CMD_SRX   = 4'hb,
      SDC_CMD_PDE   = 4'hc,
      SDC_CMD_PDX   = 4'hd,
      SDC_CMD_ZQL   = 4'he,
      SDC_CMD_ZQS   = 4'hf
   } sdc_cmd_t;

   typedef enum logic [1:0]
   {
      SDC_PW_RUN  = 2'b00,
      SDC_PW_PD   = 2'b01,
      SDC_PW_SR   = 2'b10
   } sdc_pw_t;
endpackage : sdc_pkg

// ---- core/sdc_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module sdc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop)
         begin
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sdc_fifo
`default_nettype wire

// ---- test/sdc_decoder_props.sv ----
// Concurrent checks on the ports of the command decoder.
`timescale 1ns/1ps
`default_nettype none
module sdc_decoder_props #(
   parameter int DQ_W = 16
) (
   input wire logic            clk,
   input wire logic            arst_n,
   input wire logic            wr_out_ready,
   input wire logic [DQ_W-1:0] wr_out_data,
   input wire logic [1:0]      wr_out_strb,
   input wire logic            wr_out_valid,
   input wire logic [3:0]      cmd_code,
   input wire logic            cmd_illegal,
   input wire logic [7:0]      bank_open,
   input wire logic [1:0]      power_state,
   input wire logic            burst_busy,
   input wire logic [1:0]      mode_bl,
   input wire logic            mrs_strobe,
   input wire logic            fifo_overrun
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   a_mrs_code: assert property (mrs_strobe |-> cmd_code == sdc_pkg::SDC_CMD_MRS)
      else $error("mode write strobe without its command code");
   a_illegal_quiet: assert property (cmd_illegal |-> cmd_code == 4'h0)
      else $error("refused command still shows a code");
   a_act_opens: assert property (cmd_code == sdc_pkg::SDC_CMD_ACT |-> ##[0:1] bank_open != $past(bank_open))
      else $error("activate left the open-bank map unchanged");
   a_prea_closes: assert property (cmd_code == sdc_pkg::SDC_CMD_PREA |-> ##[0:1] bank_open == 8'h00)
      else $error("all-bank precharge left a bank open");
   a_pdn_enter: assert property (cmd_code == sdc_pkg::SDC_CMD_PDE |-> ##[0:1] power_state == 2'h1)
      else $error("power-down entry not taken");
   a_pdn_exit: assert property (cmd_code == sdc_pkg::SDC_CMD_PDX |-> ##[0:1] power_state == 2'h0)
      else $error("power-down exit not taken");
   a_burst_len: assert property ($rose(burst_busy) |-> burst_busy[*2] ##[1:3] !burst_busy)
      else $error("burst length outside four or two cycles");
   a_out_hold: assert property (wr_out_valid && !wr_out_ready |=>
      wr_out_valid && $stable(wr_out_data) && $stable(wr_out_strb))
      else $error("write word changed while stalled");
   a_overrun_sticky: assert property (fifo_overrun |=> fifo_overrun)
      else $error("overrun flag cleared without reset");
   a_mode_by_mrs: assert property ($changed(mode_bl) |-> mrs_strobe || $past(mrs_strobe))
      else $error("burst mode changed without a mode write");
endmodule : sdc_decoder_props

bind sdc_decoder sdc_decoder_props #(.DQ_W(DQ_W)) i_sdc_decoder_props (
   .clk, .arst_n, .wr_out_ready, .wr_out_data, .wr_out_strb, .wr_out_valid, .cmd_code,
   .cmd_illegal, .bank_open, .power_state, .burst_busy, .mode_bl, .mrs_strobe, .fifo_overrun);
`default_nettype wire

// ---- test/sdc_ctrl_model.sv ----
// Memory controller model that drives the decoder's command and data pins.
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model (
   input  wire logic        clk,
   output var  logic        cke,
   output var  logic        cs_n,
   output var  logic        ras_n,
   output var  logic        cas_n,
   output var  logic        we_n,
   output var  logic [2:0]  bank,
   output var  logic [12:0] addr,
   output var  logic [15:0] wdata_rise,
   output var  logic [15:0] wdata_fall,
   output var  logic        low_byte_mask_rise,
   output var  logic        high_byte_mask_rise,
   output var  logic        low_byte_mask_fall,
   output var  logic        high_byte_mask_fall
);
   initial
   begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      {bank, addr, wdata_rise, wdata_fall} = '0;
      {low_byte_mask_rise, high_byte_mask_rise, low_byte_mask_fall, high_byte_mask_fall} = 4'hf;
   end

   // One command for one cycle, then no-operation; address shows its inverse once released.
   task automatic issue(input logic ck, input logic [3:0] p, input logic [2:0] b,
                        input logic [12:0] a);
      cke = ck;
      {cs_n, ras_n, cas_n, we_n} = p;
      bank = b;
      addr = a;
      @(negedge clk);
      {cs_n, ras_n, cas_n, we_n} = 4'h7;
      bank = ~b;
      addr = ~a;
   endtask : issue

   // Word i carries base plus i, low lane masked on odd i, high lane on i bits of two.
   task automatic send(input int n, input logic [15:0] base);
      for (int j = 0; j < n; j++)
      begin
         wdata_rise = base + 16'(2 * j);
         wdata_fall = base + 16'(2 * j + 1);
         low_byte_mask_rise = 1'b0;
         low_byte_mask_fall = 1'b1;
         high_byte_mask_rise = j[0];
         high_byte_mask_fall = j[0];
         @(negedge clk);
      end
      wdata_rise = ~wdata_rise;
      wdata_fall = ~wdata_fall;
   endtask : send
endmodule : sdc_ctrl_model
`default_nettype wire

// ---- test/sdc_decoder_test.sv ----
// Self-checking testbench for the command decoder.
`timescale 1ns/1ps
`default_nettype none
module sdc_decoder_test;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        wr_out_ready = 1'b1;
   logic        cke, cs_n, ras_n, cas_n, we_n, wr_out_valid, cmd_illegal, burst_busy;
   logic        low_byte_mask_rise, high_byte_mask_rise, low_byte_mask_fall, high_byte_mask_fall;
   logic        burst_is_write, zq_long, mrs_strobe, fifo_overrun;
   logic [2:0]  bank, burst_bank, mrs_sel;
   logic [12:0] addr, mrs_op;
   logic [15:0] wdata_rise, wdata_fall, wr_out_data;
   logic [1:0]  wr_out_strb, power_state, mode_bl;
   logic [3:0]  cmd_code, burst_beat;
   logic [7:0]  bank_open;
   logic [9:0]  burst_col;
   logic [17:0] got_q[$];
   int          mismatches = 0;
   int          cmp_count = 0;

   always #2 clk = ~clk;

   always @(posedge clk)
      if (wr_out_valid === 1'b1 && wr_out_ready)
         got_q.push_back({wr_out_strb, wr_out_data});

   sdc_ctrl_model i_sdc_ctrl_model (.clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank, .addr,
      .wdata_rise, .wdata_fall, .low_byte_mask_rise, .high_byte_mask_rise,
      .low_byte_mask_fall, .high_byte_mask_fall);

   sdc_decoder i_sdc_decoder (.clk, .arst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank, .addr,
      .wdata_rise, .wdata_fall, .low_byte_mask_rise, .high_byte_mask_rise,
      .low_byte_mask_fall, .high_byte_mask_fall, .wr_out_ready, .wr_out_data, .wr_out_strb,
      .wr_out_valid, .cmd_code, .cmd_illegal, .bank_open, .power_state, .burst_busy,
      .burst_is_write, .burst_beat, .burst_col, .burst_bank, .zq_long, .mode_bl, .mrs_strobe,
      .mrs_sel, .mrs_op, .fifo_overrun);

   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_n

   task automatic cmd(input logic ck, input logic [3:0] p, input logic [2:0] b,
                      input logic [12:0] a);
      i_sdc_ctrl_model.issue(ck, p, b, a);
   endtask : cmd

   // The code stands one cycle, two cycles after the pins are sampled.
   task automatic cmd_chk(input logic [3:0] p, input logic [2:0] b, input logic [12:0] a,
                          input logic [3:0] exp);
      cmd(1'b1, p, b, a);
      wait_n(2);
      check(cmd_code, exp);
   endtask : cmd_chk

   task automatic t_init;
      cmd_chk(4'h0, 3'h2, 13'h0, sdc_pkg::SDC_CMD_MRS);
      check(mrs_sel, 3'h2);
      wait_n(4);
      cmd_chk(4'hf, 3'h0, 13'h0, sdc_pkg::SDC_CMD_DES);
      cmd_chk(4'h0, 3'h0, 13'h1, sdc_pkg::SDC_CMD_MRS);
      check({mrs_strobe, mrs_op}, 18'h2001);
      wait_n(1);
      check(mode_bl, sdc_pkg::BL_OTF);
      cmd_chk(4'h6, 3'h0, 13'h400, sdc_pkg::SDC_CMD_ZQL);
      wait_n(1);
      check(zq_long, 1'b1);
      cmd_chk(4'h6, 3'h0, 13'h0, sdc_pkg::SDC_CMD_ZQS);
      wait_n(1);
      check(zq_long, 1'b0);
   endtask : t_init

   task automatic t_bank;
      cmd_chk(4'h3, 3'h3, 13'h0123, sdc_pkg::SDC_CMD_ACT);
      wait_n(1);
      check(bank_open, 8'h08);
      cmd_chk(4'h3, 3'h3, 13'h0123, 4'h0);
      check(cmd_illegal, 1'b1);
      cmd_chk(4'h5, 3'h5, 13'h0, 4'h0);
      check(cmd_illegal, 1'b1);
      cmd_chk(4'h3, 3'h5, 13'h0, sdc_pkg::SDC_CMD_ACT);
   endtask : t_bank

   task automatic t_write(input logic a12, input int n);
      int k;
      got_q.delete();
      cmd(1'b1, 4'h4, 3'h3, {a12, 12'h010});
      i_sdc_ctrl_model.send(n / 2, 16'ha000);
      for (k = 0; k < 60 && got_q.size() < n; k++)
         wait_n(1);
      check(18'(got_q.size()), 18'(n));
      check({burst_is_write, burst_bank, burst_col}, {1'b1, 3'h3, 10'h010});
      for (k = 0; k < n; k++)
         check(got_q[k], {~k[1], ~k[0], 16'ha000 + 16'(k)});
   endtask : t_write

   task automatic t_read(input logic a12, input logic a10, input int exp);
      int busy = 0;
      cmd(1'b1, 4'h5, 3'h5, {a12, 1'b0, a10, 10'h020});
      repeat (12)
      begin
         wait_n(1);
         if (burst_busy === 1'b1)
            busy++;
      end
      check(18'(busy), 18'(exp));
      check({burst_is_write, burst_bank, burst_col, burst_beat},
            {1'b0, 3'h5, 10'h020, 4'(2 * exp)});
      check(bank_open[5], !a10);
   endtask : t_read

   task automatic t_pre;
      cmd_chk(4'h2, 3'h3, 13'h0, sdc_pkg::SDC_CMD_PRE);
      wait_n(1);
      check(bank_open, 8'h00);
      cmd(1'b1, 4'h3, 3'h3, 13'h0);
      wait_n(1);
      cmd(1'b1, 4'h3, 3'h4, 13'h0);
      wait_n(4);
      check(bank_open, 8'h18);
      cmd_chk(4'h2, 3'h0, 13'h400, sdc_pkg::SDC_CMD_PREA);
      wait_n(1);
      check(bank_open, 8'h00);
   endtask : t_pre

   task automatic t_fixed;
      cmd_chk(4'h0, 3'h0, 13'h0, sdc_pkg::SDC_CMD_MRS);
      wait_n(1);
      check(mode_bl, sdc_pkg::BL_FIXED8);
      cmd(1'b1, 4'h3, 3'h5, 13'h0);
      wait_n(3);
      t_read(1'b0, 1'b1, 4);
   endtask : t_fixed

   task automatic t_power;
      cmd_chk(4'h1, 3'h0, 13'h0, sdc_pkg::SDC_CMD_REF);
      cmd(1'b0, 4'h7, 3'h0, 13'h0);
      wait_n(6);
      check(power_state, 2'h1);
      cmd(1'b1, 4'h7, 3'h0, 13'h0);
      wait_n(6);
      check(power_state, 2'h0);
      cmd(1'b0, 4'h1, 3'h0, 13'h0);
      wait_n(6);
      check(power_state, 2'h2);
      cmd(1'b1, 4'h7, 3'h0, 13'h0);
      wait_n(6);
      check(power_state, 2'h0);
   endtask : t_power

   // The sink stalls while nine full bursts arrive: 36 word pairs, more than 32 entries.
   task automatic t_overrun;
      int k;
      wr_out_ready = 1'b0;
      cmd(1'b1, 4'h3, 3'h3, 13'h0);
      wait_n(3);
      for (k = 0; k < 9; k++)
      begin
         cmd(1'b1, 4'h4, 3'h3, 13'h0);
         i_sdc_ctrl_model.send(4, 16'h5000);
         wait_n(2);
      end
      check(fifo_overrun, 1'b1);
      wr_out_ready = 1'b1;
      for (k = 0; k < 300 && wr_out_valid !== 1'b0; k++)
         wait_n(1);
      check(wr_out_valid, 1'b0);
   endtask : t_overrun

   initial
   begin
      wait_n(16);
      arst_n = 1'b1;
      wait_n(2);
      t_init;
      t_bank;
      t_write(1'b0, 4);
      t_write(1'b1, 8);
      t_read(1'b0, 1'b0, 2);
      t_read(1'b1, 1'b0, 4);
      t_read(1'b1, 1'b1, 4);
      t_pre;
      t_fixed;
      t_power;
      t_overrun;
      finish_test;
   end

   // The sequence needs a few hundred cycles; ten thousand means a hang.
   initial
   begin
      #40000;
      mismatches++;
      finish_test;
   end
endmodule : sdc_decoder_test
`default_nettype wire
